// File: src/tsr_pkg.sv
// Purpose: Shared constants and types for the temperature sensor register bank
// Assumes: 16-bit register words, 8-bit sub-addresses
// Notes:   Every offset, reset value and field constant lives here

package tsr_pkg;

    // ********************************
    // Widths and depths
    // ********************************
    localparam int WORD_W = 16;
    localparam int RES_W = 14;
    localparam int BUF_DEPTH = 10;
    localparam int NUM_RW = 6;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] ADDR_TEMP = 8'h00;
    localparam logic [7:0] ADDR_SLEW = 8'h01;
    localparam logic [7:0] ADDR_ALERT = 8'h02;
    localparam logic [7:0] ADDR_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_LOW = 8'h05;
    localparam logic [7:0] ADDR_HIGH = 8'h06;
    localparam logic [7:0] ADDR_HYST = 8'h07;
    localparam logic [7:0] ADDR_SLEWLIM = 8'h08;
    localparam logic [7:0] ADDR_SN1 = 8'h09;
    localparam logic [7:0] ADDR_SN2 = 8'h0A;
    localparam logic [7:0] ADDR_SN3 = 8'h0B;
    localparam logic [7:0] ADDR_PART = 8'h0C;

    // ********************************
    // Reset values, writable block in address order
    // ********************************
    localparam logic [15:0] RST_CONFIG = 16'h0006;
    localparam logic [15:0] RST_MASK = 16'h0016;
    localparam logic [15:0] RST_LOW = 16'hF380;
    localparam logic [15:0] RST_HIGH = 16'h2A80;
    localparam logic [15:0] RST_HYST = 16'h0A0A;
    localparam logic [15:0] RST_SLEWLIM = 16'h0500;
    localparam logic [15:0] RW_RESET [NUM_RW] = '{RST_CONFIG, RST_MASK, RST_LOW,
        RST_HIGH, RST_HYST, RST_SLEWLIM};
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ********************************
    // Checksum and framing
    // ********************************
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [3:0] LEN_NONE = 4'h0;
    localparam logic [3:0] LEN_MAX = 4'hA;
    localparam logic [3:0] LEN_ONE = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [1:0] RES_PAD = 2'h0;

    // ********************************
    // Alert flag layout
    // ********************************
    localparam logic [7:0] ALERT_RC_MASK = 8'hA7;
    localparam logic [7:0] ALERT_ST_MASK = 8'h58;
    localparam logic [7:0] ALERT_CRC_FLAG = 8'h80;
    localparam logic [7:0] ALERT_NONE = 8'h00;

    // Conversions seen in continuous mode
    localparam logic [1:0] MEAS_NONE = 2'h0;
    localparam logic [1:0] MEAS_ONE = 2'h1;
    localparam logic [1:0] MEAS_TWO = 2'h2;

    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic spare;
        logic crc_req;
        logic [3:0] len;
        logic ainc;
        logic rd;
        logic [7:0] addr;
    } tsr_cmd_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] alert_mask;
        logic [15:0] low_limit;
        logic [15:0] high_limit;
        logic [15:0] hysteresis;
        logic [15:0] slew_limit;
    } tsr_ctrl_t;

    typedef enum {ST_CMD, ST_WRITE, ST_READ, ST_COMMIT, ST_DONE} tsr_state_t;

endpackage : tsr_pkg

// File: src/tsr_crc_fold.sv
// Purpose: One word step of the 16-bit transfer checksum
// Assumes: Caller holds the accumulator
// Notes:   Purely combinational

module tsr_crc_fold
    import tsr_pkg::*;
(
    input wire logic [15:0] acc_in,
    input wire logic [15:0] word_in,
    output logic [15:0] nxt_out
);

    // ********************************
    // Fold then sixteen MSB-first shifts
    // ********************************
    always_comb begin
        nxt_out = acc_in ^ word_in;
        for (int i = 0; i < WORD_W; i++) begin
            if (nxt_out[WORD_W-1]) begin
                nxt_out = {nxt_out[WORD_W-2:0], 1'b0} ^ CRC_POLY;
            end else begin
                nxt_out = {nxt_out[WORD_W-2:0], 1'b0};
            end
        end
    end

endmodule : tsr_crc_fold

// File: src/tsr_regbank.sv
// Purpose: Register bank behind the three-wire serial port of a temperature sensor
// Assumes: SCLK and the data line are sampled as synchronous inputs on REF_CLK_IN
// Notes:   Idle serial clock low; data sampled on rising, driven on falling edge

module tsr_regbank
    import tsr_pkg::*;
#(
    // Identifier values are arbitrary
    parameter logic [15:0] SERIAL_WORD1 = 16'h1357,
    parameter logic [15:0] SERIAL_WORD2 = 16'h2468,
    parameter logic [15:0] SERIAL_WORD3 = 16'h3579,
    parameter logic [15:0] PART_CODE = 16'h5A01
)
(
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic CS_N_IN,
    input wire logic SCLK_IN,
    input wire logic SERIAL_LINE_IN,
    input wire logic CONT_MODE_IN,
    input wire logic TEMP_VALID_IN,
    input wire logic [13:0] TEMP_DATA_IN,
    input wire logic [13:0] SLEW_DATA_IN,
    input wire logic [7:0] ALERT_EVENT_IN,
    input wire logic [7:0] ALERT_STATUS_IN,
    output logic SERIAL_LINE_OUT,
    output logic SERIAL_LINE_OE_N_OUT,
    output tsr_ctrl_t CTRL_OUT,
    output logic [7:0] ALERT_FLAGS_OUT
);

    // ********************************
    // Declarations
    // ********************************
    tsr_state_t st_r;
    tsr_state_t st_nxt;
    tsr_cmd_t cmd_r;
    logic sclk_q_r;
    logic crc_on_r;
    logic [3:0] bit_cnt_r;
    logic [3:0] tx_cnt_r;
    logic [3:0] wcnt_r;
    logic [3:0] cidx_r;
    logic [7:0] ptr_r;
    logic [7:0] alert_r;
    logic [1:0] meas_r;
    logic [15:0] rx_sh_r;
    logic [15:0] tx_sh_r;
    logic [15:0] crc_r;
    logic [15:0] temp_r;
    logic [15:0] slew_r;
    logic [15:0] rw_r [NUM_RW];
    logic [15:0] wbuf [BUF_DEPTH];

    // ********************************
    // Serial edge and frame decode
    // ********************************
    wire active = !CS_N_IN;
    wire rise = SCLK_IN && !sclk_q_r;
    wire fall = !SCLK_IN && sclk_q_r;
    wire rx_phase = (st_r == ST_CMD) || (st_r == ST_WRITE);
    wire word_done = active && rise && rx_phase && (bit_cnt_r == BIT_LAST);
    wire [15:0] rx_word = {rx_sh_r[14:0], SERIAL_LINE_IN};
    wire tsr_cmd_t new_cmd = tsr_cmd_t'(rx_word);
    wire cmd_done = word_done && (st_r == ST_CMD);
    wire new_crc_on = new_cmd.crc_req && (new_cmd.len != LEN_NONE) && (new_cmd.len <= LEN_MAX);
    wire crc_slot = crc_on_r && (wcnt_r == cmd_r.len);
    wire wr_word_done = word_done && (st_r == ST_WRITE);
    wire direct_wr = wr_word_done && !crc_on_r;
    wire buf_wr = wr_word_done && crc_on_r && !crc_slot;
    wire crc_chk = wr_word_done && crc_slot;
    wire crc_ok = (rx_word == crc_r);
    wire tx_load = active && fall && (st_r == ST_READ) && (tx_cnt_r == CNT_ZERO);
    wire read_end = tx_load && crc_on_r && (wcnt_r > cmd_r.len);
    wire data_load = tx_load && !crc_slot && !read_end;
    wire commit = (st_r == ST_COMMIT);
    wire commit_last = commit && (cidx_r == cmd_r.len - LEN_ONE);
    wire ptr_step = cmd_r.ainc && (direct_wr || data_load);

    // ********************************
    // Read selection
    // ********************************
    wire rd_rw_hit = (ptr_r >= ADDR_CONFIG) && (ptr_r <= ADDR_SLEWLIM);
    wire [7:0] rd_off = ptr_r - ADDR_CONFIG;
    wire [15:0] rd_word = (ptr_r == ADDR_TEMP) ? temp_r :
                          (ptr_r == ADDR_SLEW) ? slew_r :
                          (ptr_r == ADDR_ALERT) ? {ALERT_NONE, alert_r} :
                          rd_rw_hit ? rw_r[rd_off[2:0]] :
                          (ptr_r == ADDR_SN1) ? SERIAL_WORD1 :
                          (ptr_r == ADDR_SN2) ? SERIAL_WORD2 :
                          (ptr_r == ADDR_SN3) ? SERIAL_WORD3 :
                          (ptr_r == ADDR_PART) ? PART_CODE :
                          WORD_ZERO;
    wire [15:0] load_word = crc_slot ? crc_r : rd_word;
    wire rc_clr = data_load && (ptr_r == ADDR_ALERT) && !cmd_r.ainc;

    // ********************************
    // Write selection
    // ********************************
    wire [7:0] commit_addr = cmd_r.ainc ? cmd_r.addr + {4'h0, cidx_r} : cmd_r.addr;
    wire wr_en = direct_wr || commit;
    wire [7:0] wr_addr = commit ? commit_addr : ptr_r;
    wire [15:0] wr_data = commit ? wbuf[cidx_r] : rx_word;
    wire wr_any_hit = (wr_addr >= ADDR_CONFIG) && (wr_addr <= ADDR_SLEWLIM);

    // ********************************
    // Checksum step
    // ********************************
    wire [15:0] fold_acc = cmd_done ? CRC_SEED : crc_r;
    wire [15:0] fold_word = (st_r == ST_READ) ? rd_word : rx_word;
    wire fold_take = cmd_done || buf_wr || data_load;
    logic [15:0] fold_nxt;

    tsr_crc_fold u_crc (
        .acc_in(fold_acc),
        .word_in(fold_word),
        .nxt_out(fold_nxt)
    );

    // ********************************
    // Frame state
    // ********************************
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_CMD: begin
                if (cmd_done) begin
                    st_nxt = new_cmd.rd ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (crc_chk) begin
                    st_nxt = crc_ok ? ST_COMMIT : ST_DONE;
                end
            end
            ST_READ: begin
                if (read_end) begin
                    st_nxt = ST_DONE;
                end
            end
            ST_COMMIT: begin
                if (commit_last) begin
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                st_nxt = ST_DONE;
            end
            default: begin
                st_nxt = ST_CMD;
            end
        endcase
        if (!active && (st_nxt != ST_COMMIT)) begin
            st_nxt = ST_CMD;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            st_r <= ST_CMD;
            sclk_q_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sclk_q_r <= SCLK_IN;
        end
    end

    // ********************************
    // Receive shifter and command capture
    // ********************************
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN || !active) begin
            bit_cnt_r <= CNT_ZERO;
            rx_sh_r <= WORD_ZERO;
        end else if (rise && rx_phase) begin
            bit_cnt_r <= bit_cnt_r + LEN_ONE;
            rx_sh_r <= rx_word;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            cmd_r <= tsr_cmd_t'(WORD_ZERO);
            crc_on_r <= 1'b0;
            ptr_r <= ADDR_TEMP;
        end else if (cmd_done) begin
            cmd_r <= new_cmd;
            crc_on_r <= new_crc_on;
            ptr_r <= new_cmd.addr;
        end else if (ptr_step) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // ********************************
    // Checksum accumulator and word counts
    // ********************************
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            crc_r <= CRC_SEED;
        end else if (fold_take) begin
            crc_r <= fold_nxt;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN || cmd_done) begin
            wcnt_r <= CNT_ZERO;
            cidx_r <= CNT_ZERO;
        end else begin
            if (buf_wr || tx_load) begin
                wcnt_r <= wcnt_r + LEN_ONE;
            end
            if (commit) begin
                cidx_r <= cidx_r + LEN_ONE;
            end
        end
    end

    // Held until the checksum proves the whole block
    always_ff @(posedge REF_CLK_IN) begin
        if (buf_wr) begin
            wbuf[wcnt_r] <= rx_word;
        end
    end

    // ********************************
    // Transmit shifter
    // ********************************
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            SERIAL_LINE_OUT <= 1'b0;
            SERIAL_LINE_OE_N_OUT <= 1'b1;
            tx_sh_r <= WORD_ZERO;
            tx_cnt_r <= CNT_ZERO;
        end else if ((st_r != ST_READ) || read_end || !active) begin
            SERIAL_LINE_OE_N_OUT <= 1'b1;
            tx_cnt_r <= CNT_ZERO;
        end else if (tx_load) begin
            SERIAL_LINE_OUT <= load_word[WORD_W-1];
            tx_sh_r <= {load_word[WORD_W-2:0], 1'b0};
            tx_cnt_r <= BIT_LAST;
            SERIAL_LINE_OE_N_OUT <= 1'b0;
        end else if (fall && (tx_cnt_r != CNT_ZERO)) begin
            SERIAL_LINE_OUT <= tx_sh_r[WORD_W-1];
            tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
            tx_cnt_r <= tx_cnt_r - LEN_ONE;
        end
    end

    // ********************************
    // Writable registers
    // ********************************
    generate
        for (genvar g = 0; g < NUM_RW; g++) begin : g_rw
            wire hit = wr_en && (wr_addr == ADDR_CONFIG + 8'(g));
            always_ff @(posedge REF_CLK_IN) begin
                if (RESET_IN) begin
                    rw_r[g] <= RW_RESET[g];
                end else if (hit) begin
                    rw_r[g] <= wr_data;
                end
            end
        end
    endgenerate

    assign CTRL_OUT = tsr_ctrl_t'({rw_r[0], rw_r[1], rw_r[2], rw_r[3], rw_r[4], rw_r[5]});

    // ********************************
    // Conversion results
    // ********************************
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            temp_r <= WORD_ZERO;
        end else if (TEMP_VALID_IN) begin
            temp_r <= {TEMP_DATA_IN, RES_PAD};
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN || !CONT_MODE_IN) begin
            slew_r <= WORD_ZERO;
            meas_r <= MEAS_NONE;
        end else if (TEMP_VALID_IN) begin
            if (meas_r != MEAS_NONE) begin
                slew_r <= {SLEW_DATA_IN, RES_PAD};
            end
            if (meas_r != MEAS_TWO) begin
                meas_r <= meas_r + MEAS_ONE;
            end
        end
    end

    // ********************************
    // Alert flags, set wins over read clear
    // ********************************
    wire [7:0] crc_fault = (crc_chk && !crc_ok) ? ALERT_CRC_FLAG : ALERT_NONE;
    wire [7:0] rc_keep = rc_clr ? ALERT_NONE : (alert_r & ALERT_RC_MASK);
    wire [7:0] alert_nxt = rc_keep | (ALERT_EVENT_IN & ALERT_RC_MASK) | crc_fault
                           | (ALERT_STATUS_IN & ALERT_ST_MASK);

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            alert_r <= ALERT_NONE;
        end else begin
            alert_r <= alert_nxt;
        end
    end

    assign ALERT_FLAGS_OUT = alert_r;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    sequence s_single_alert_read;
        rc_clr && (ALERT_EVENT_IN == ALERT_NONE);
    endsequence

    sequence s_crc_mismatch;
        crc_chk && !crc_ok;
    endsequence

    sequence s_second_conv;
        CONT_MODE_IN && TEMP_VALID_IN && (meas_r != MEAS_NONE);
    endsequence

    a_crc_seed_start: assert property (cmd_done |-> (fold_acc == CRC_SEED))
        else $error("checksum not seeded with all ones");

    a_crc_fold_take: assert property (fold_take |=> (crc_r == $past(fold_nxt)))
        else $error("checksum accumulator missed a word");

    a_temp_format: assert property (TEMP_VALID_IN |=> (temp_r == {$past(TEMP_DATA_IN), RES_PAD}))
        else $error("temperature word not placed in bits 15:2");

    a_temp_pad_zero: assert property ((temp_r[1:0] == RES_PAD) && (slew_r[1:0] == RES_PAD))
        else $error("result pad bits not zero");

    a_slew_wait_two: assert property ((CONT_MODE_IN && (meas_r == MEAS_NONE)) |=> (slew_r == WORD_ZERO))
        else $error("slew shown before two conversions");

    a_slew_revert: assert property (!CONT_MODE_IN |=> (slew_r == WORD_ZERO) ##1 (slew_r == WORD_ZERO)
        or CONT_MODE_IN)
        else $error("slew not cleared outside continuous mode");

    a_slew_format: assert property (s_second_conv |=> (slew_r == {$past(SLEW_DATA_IN), RES_PAD}))
        else $error("slew word not placed in bits 15:2");

    a_reset_defaults: assert property ($past(RESET_IN) |-> (rw_r[0] == RST_CONFIG) && (rw_r[1] == RST_MASK)
        && (rw_r[2] == RST_LOW) && (rw_r[3] == RST_HIGH) && (rw_r[4] == RST_HYST)
        && (rw_r[5] == RST_SLEWLIM))
        else $error("register defaults wrong after reset");

    a_unmapped_write: assert property ((wr_en && !wr_any_hit) |=> $stable(CTRL_OUT))
        else $error("write outside writable block changed a register");

    a_crc_fault_flag: assert property (s_crc_mismatch |=> alert_r[7] && (st_r != ST_COMMIT))
        else $error("bad checksum did not raise fault or was committed");

    a_rc_clear: assert property (s_single_alert_read |=> ((alert_r & ALERT_RC_MASK) == ALERT_NONE))
        else $error("single alert read did not clear flags");

    a_burst_no_clear: assert property ((data_load && cmd_r.ainc) |=>
        ((alert_r & ALERT_RC_MASK) == (($past(alert_r) | $past(ALERT_EVENT_IN) | $past(crc_fault))
        & ALERT_RC_MASK)))
        else $error("burst read cleared alert flags");

    a_line_release: assert property (!active |=> SERIAL_LINE_OE_N_OUT)
        else $error("data line driven outside a frame");

endmodule : tsr_regbank

// File: tb/tsr_host.sv
// Purpose: Serial host model driving frames into the register bank
// Assumes: Host changes its lines on falling REF_CLK edges
// Notes:   Released line toggles so stale bits never look valid

module tsr_host (
    input wire logic clk_in,
    input wire logic sio_out_in,
    input wire logic oe_n_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic sio_in_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_bit_r = 1'b0;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    assign sio_in_out = oe_n_in ? host_bit_r : sio_out_in;

    task automatic start_frame();
        @(negedge clk_in);
        cs_n_out = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask : start_frame

    task automatic stop_frame();
        cs_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask : stop_frame

    // Words MSB first; each SCLK phase lasts two cycles
    task automatic xfer(input logic [15:0] w, input bit rd, output logic [15:0] r);
        for (int i = 15; i >= 0; i--) begin
            host_bit_r = rd ? ~host_bit_r : w[i];
            sclk_out = 1'b1;
            repeat (2) @(negedge clk_in);
            r[i] = sio_in_out;
            sclk_out = 1'b0;
            repeat (2) @(negedge clk_in);
        end
    endtask : xfer
endmodule : tsr_host

// File: tb/tsr_regbank_bench.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the serial frames
// Notes:   Register model compared at every read and check

module tsr_regbank_bench import tsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Identifier values are arbitrary
    localparam logic [15:0] ID1 = 16'h0C1A, ID2 = 16'h0C2B, ID3 = 16'h0C3C, IDP = 16'h7E55;
    logic clk, rst, cs_n, sclk, sio_in, cont, tvalid, sio_out, oe_n;
    logic [13:0] tdata, sdata;
    logic [7:0] aev, ast, aflags, sticky;
    tsr_ctrl_t ctrl;
    logic [15:0] mdl [0:255];
    logic [15:0] wq [$];
    int num_errors = 0, checks_done = 0, cnt = 0, seed = 24;

    tsr_regbank #(.SERIAL_WORD1(ID1), .SERIAL_WORD2(ID2), .SERIAL_WORD3(ID3), .PART_CODE(IDP)) uut (
        .REF_CLK_IN(clk), .RESET_IN(rst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .SERIAL_LINE_IN(sio_in),
        .CONT_MODE_IN(cont), .TEMP_VALID_IN(tvalid), .TEMP_DATA_IN(tdata), .SLEW_DATA_IN(sdata),
        .ALERT_EVENT_IN(aev), .ALERT_STATUS_IN(ast), .SERIAL_LINE_OUT(sio_out),
        .SERIAL_LINE_OE_N_OUT(oe_n), .CTRL_OUT(ctrl), .ALERT_FLAGS_OUT(aflags));
    tsr_host host (.clk_in(clk), .sio_out_in(sio_out), .oe_n_in(oe_n), .cs_n_out(cs_n),
        .sclk_out(sclk), .sio_in_out(sio_in));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************
    // Model and checks
    // ****************************************
    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic mreset();
        foreach (mdl[i]) mdl[i] = 16'h0000;
        for (int i = 0; i < NUM_RW; i++) mdl[3 + i] = RW_RESET[i];
        mdl[9] = ID1;
        mdl[10] = ID2;
        mdl[11] = ID3;
        mdl[12] = IDP;
        sticky = 8'h00;
        cnt = 0;
    endtask : mreset

    function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic [15:0] w);
        acc = acc ^ w;
        for (int b = 0; b < 16; b++)
            acc = acc[15] ? ((acc << 1) ^ CRC_POLY) : (acc << 1);
        return acc;
    endfunction : crc_step

    function automatic logic [15:0] cmd(bit c, logic [3:0] l, bit ai, bit rd, logic [7:0] a);
        return {1'b0, c, l, ai, rd, a};
    endfunction : cmd

    function automatic logic [15:0] exp_rd(logic [7:0] a);
        return (a == ADDR_ALERT) ? {8'h00, sticky | (ast & ALERT_ST_MASK)} : mdl[a];
    endfunction : exp_rd

    task automatic ctrl_chk();
        for (int i = 0; i < NUM_RW; i++) chk(mdl[3 + i], ctrl[95 - 16 * i -: 16]);
    endtask : ctrl_chk

    task automatic flag_chk();
        chk({8'h00, sticky | (ast & ALERT_ST_MASK)}, {8'h00, aflags});
    endtask : flag_chk

    task automatic fill(input int n);
        wq = {};
        repeat (n) wq.push_back(16'($random(seed)));
    endtask : fill

    // One frame; writes land in the model at once, or after the frame if checksum protected and good
    task automatic access(input logic [15:0] c, input int n, input bit bad);
        logic [15:0] r, acc, d;
        logic [7:0] ad;
        bit prot;
        prot = c[14] && c[13:10] != LEN_NONE && c[13:10] <= LEN_MAX;
        acc = crc_step(CRC_SEED, c);
        host.start_frame();
        host.xfer(c, 1'b0, r);
        for (int k = 0; k < n; k++) begin
            ad = c[7:0] + (c[9] ? k : 0);
            d = c[8] ? exp_rd(ad) : wq[k];
            host.xfer(wq.size() > k ? wq[k] : WORD_ZERO, c[8], r);
            acc = crc_step(acc, d);
            if (c[8]) chk(d, r);
            if (c[8] && ad == ADDR_ALERT && !c[9]) sticky = 8'h00;
            if (!c[8] && !prot && ad >= ADDR_CONFIG && ad <= ADDR_SLEWLIM) mdl[ad] = d;
        end
        if (prot) begin
            host.xfer(acc ^ {15'h0000, bad}, c[8], r);
            if (c[8]) chk(acc, r);
        end
        host.stop_frame();
        if (prot && !c[8] && bad) sticky = sticky | ALERT_CRC_FLAG;
        for (int k = 0; k < n; k++)
            if (prot && !c[8] && !bad) mdl[c[7:0] + (c[9] ? k : 0)] = wq[k];
    endtask : access

    task automatic conv(input logic [13:0] s);
        @(negedge clk);
        tvalid = 1'b1;
        tdata = 14'($random(seed));
        sdata = s;
        mdl[0] = {tdata, RES_PAD};
        cnt = cnt + (cont ? 1 : 0);
        if (cnt >= 2) mdl[1] = {s, RES_PAD};
        @(negedge clk);
        tvalid = 1'b0;
    endtask : conv

    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        cont = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        mreset();
        // Status bits reach the flags one edge after release
        @(negedge clk);
    endtask : do_reset

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        print_verdict();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst, cont, tvalid, tdata, sdata, aev} = '0;
        rst = 1'b1;
        ast = 8'($random(seed));
        do_reset();
        ctrl_chk();
        access(cmd(0, 0, 1, 1, ADDR_CONFIG), 6, 0);
        access(cmd(0, 0, 1, 1, ADDR_SN1), 8, 0);
        fill(13);
        access(cmd(0, 0, 1, 0, ADDR_TEMP), 13, 0);
        ctrl_chk();
        access(cmd(0, 0, 1, 1, ADDR_TEMP), 16, 0);
        fill(2);
        access(cmd(0, 0, 0, 0, ADDR_LOW), 2, 0);
        access(cmd(0, 0, 0, 0, 8'hF0), 2, 0);
        access(cmd(0, 0, 0, 1, 8'hF0), 1, 0);
        for (int s = 0; s < 4; s++) begin
            @(negedge clk);
            cont = (s == 1 || s == 2);
            if (!cont) mdl[1] = WORD_ZERO;
            if (!cont) cnt = 0;
            if (s < 3) conv(14'($random(seed)) | 14'h2000);
            access(cmd(0, 0, 1, 1, ADDR_TEMP), 2, 0);
        end
        fill(2);
        access(cmd(1, 2, 1, 0, ADDR_LOW), 2, 0);
        fill(1);
        access(cmd(1, 1, 0, 0, ADDR_HYST), 1, 1);
        flag_chk();
        access(cmd(1, LEN_MAX, 1, 1, ADDR_TEMP), 10, 0);
        fill(1);
        access(cmd(1, 4'hB, 0, 0, ADDR_HIGH), 1, 0);
        ctrl_chk();
        @(negedge clk);
        aev = 8'($random(seed));
        sticky = sticky | (aev & ALERT_RC_MASK);
        @(negedge clk);
        aev = 8'h00;
        @(negedge clk);
        flag_chk();
        access(cmd(0, 0, 1, 1, ADDR_ALERT), 2, 0);
        flag_chk();
        access(cmd(0, 0, 0, 1, ADDR_ALERT), 1, 0);
        flag_chk();
        do_reset();
        ctrl_chk();
        flag_chk();
        access(cmd(0, 0, 1, 1, ADDR_TEMP), 2, 0);
        print_verdict();
    end
endmodule : tsr_regbank_bench
